// ### hdl/ric_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ric_map.svh"

// Operation
// - press and release 0.15-4 s unlocks
// - press of 4 s or more is discarded
// - line active 30 s gives fault lock
// - red lamp lit while locked, outputs off
// - yellow lamp when locked, clear and lock enabled
// - clear and not locked: green, outputs on
// - alignment display shows flashing segments
// - marginal beams flash green, lost beam red
// - trip or power fail returns to locked
// - shared line is button and inverse lamp
module ric_top
   import ric_pkg::*;
#(
   parameter logic [31:0] MIN_HOLD_CYC = 32'(64'(`RIC_MIN_HOLD_MS) * 64'(`RIC_CLK_KHZ)),
   parameter logic [31:0] MAX_HOLD_CYC = 32'(64'(`RIC_MAX_HOLD_MS) * 64'(`RIC_CLK_KHZ)),
   parameter logic [31:0] SHORT_CYC    = 32'(64'(`RIC_SHORT_MS) * 64'(`RIC_CLK_KHZ)),
   parameter logic [31:0] FLASH_CYC    = 32'(64'(`RIC_FLASH_MS) * 64'(`RIC_CLK_KHZ))
) (
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       reset_button_line_i,     // shared line level at the pin
   input  wire logic       interlock_select_input_i,// select pin level
   input  wire logic       field_clear_i,           // all beams received
   input  wire logic       marginal_align_i,        // beams received but weak
   input  wire logic       power_fail_i,            // supply monitor trips
   input  wire logic       align_display_en_i,      // alignment display active
   output logic            safety_output_a_o,
   output logic            safety_output_b_o,
   output logic            reset_button_line_o,     // lamp drive level
   output logic            reset_button_line_oe_o,  // lamp driving the line
   output logic            red_lamp_o,
   output logic            yellow_lamp_o,
   output logic            status_green_o,          // first status lamp green
   output logic            status_red_o,            // first status lamp red
   output logic [6:0]      segment_o,
   output logic            interlock_fault_o,
   output logic            restart_lock_function_o  // lock mode in force
);

   ric_st_t st_ff;      // registered state
   ric_st_t nxt_st;     // next state
   logic    sample_w;   // line released and settled
   logic    btn_w;      // debounced button level
   logic    rise_w;     // press edge
   logic    fall_w;     // release edge
   logic    on_w;       // next state is ON

   // ************************************************************
   // button conditioning
   // ************************************************************
   assign sample_w = (st_ff.mux == `RIC_MUX_SAMPLE);

   ric_debounce u_db (
      .clk_i    (clk_i),
      .rst_b_i  (rst_b_i),
      .pin_i    (reset_button_line_i),
      .sample_i (sample_w),
      .level_o  (btn_w)
   );

   assign rise_w = btn_w & ~st_ff.btn_prev;
   assign fall_w = ~btn_w & st_ff.btn_prev;

   // ************************************************************
   // interlock sequencing and indicators
   // ************************************************************
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.sel_sync1 = interlock_select_input_i;
      nxt_st.sel_sync2 = st_ff.sel_sync1;
      nxt_st.mux       = st_ff.mux + 8'h01;
      nxt_st.btn_prev  = btn_w;

      // select is read only while the lamp is off the line and nobody presses,
      // since a bridged select would otherwise see the lamp drive as enable
      if (sample_w && !btn_w) begin
         nxt_st.lock_en = st_ff.sel_sync2;
      end

      // a button held at power-up still counts, since the debounced level starts low from reset
      if (!btn_w) begin
         nxt_st.armed = 1'b1;
      end
      if (rise_w) begin
         nxt_st.req_ok = st_ff.armed;
      end

      // press duration, saturating so the fault check sees a stable value
      if (btn_w) begin
         if (st_ff.hold != SHORT_CYC) begin
            nxt_st.hold = st_ff.hold + 32'h1;
         end
         if (st_ff.hold >= MAX_HOLD_CYC - 32'h1) begin
            nxt_st.req_ok = 1'b0;
         end
      end else begin
         nxt_st.hold = 32'h0;
      end

      // shared blink base for lamp and display
      if (st_ff.flash_cnt >= FLASH_CYC - 32'h1) begin
         nxt_st.flash_cnt = 32'h0;
         nxt_st.flash     = ~st_ff.flash;
      end else begin
         nxt_st.flash_cnt = st_ff.flash_cnt + 32'h1;
      end

      unique case (st_ff.state)
         RIC_LOCKED: begin
            if (field_clear_i && !power_fail_i) begin
               if (!st_ff.lock_en) begin
                  nxt_st.state = RIC_ON;
               end else if (fall_w && st_ff.req_ok && st_ff.hold >= MIN_HOLD_CYC
                            && st_ff.hold < MAX_HOLD_CYC) begin
                  nxt_st.state = RIC_ON;
               end
            end
         end
         RIC_ON: begin
            if (!field_clear_i || power_fail_i) begin
               nxt_st.state = RIC_LOCKED;
            end
         end
         RIC_FAULT: begin
            // only a reset leaves the fault lock
            nxt_st.state = RIC_FAULT;
         end
         default: begin
            nxt_st.state = RIC_LOCKED;
         end
      endcase

      // a line stuck active is a short to the supply, whatever the state
      if (st_ff.state != RIC_FAULT && btn_w && st_ff.hold == SHORT_CYC - 32'h1) begin
         nxt_st.state = RIC_FAULT;
      end

      on_w            = (nxt_st.state == RIC_ON);
      nxt_st.out_a    = on_w;
      nxt_st.out_b    = on_w;
      nxt_st.line     = ~on_w;
      // lamp lets go of the line briefly so the button can be read
      nxt_st.line_oe  = ~on_w && (nxt_st.mux < `RIC_MUX_RELEASE);
      nxt_st.red      = ~on_w;
      nxt_st.yellow   = (nxt_st.state == RIC_LOCKED) && field_clear_i && nxt_st.lock_en;
      nxt_st.fault    = (nxt_st.state == RIC_FAULT);
      nxt_st.st_green = field_clear_i && !nxt_st.fault &&
                        (marginal_align_i ? nxt_st.flash : on_w);
      nxt_st.st_red   = !field_clear_i || nxt_st.fault ||
                        (!on_w && !marginal_align_i);
      nxt_st.seg      = (align_display_en_i && nxt_st.flash) ? `RIC_SEG_ALL : `RIC_SEG_NONE;
   end

   // state register; lock mode defaults to enabled, the safe side
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff         <= '0;
         st_ff.lock_en <= 1'b1;
         st_ff.line    <= 1'b1;
         st_ff.red     <= 1'b1;
         st_ff.st_red  <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign safety_output_a_o       = st_ff.out_a;
   assign safety_output_b_o       = st_ff.out_b;
   assign reset_button_line_o     = st_ff.line;
   assign reset_button_line_oe_o  = st_ff.line_oe;
   assign red_lamp_o              = st_ff.red;
   assign yellow_lamp_o           = st_ff.yellow;
   assign status_green_o          = st_ff.st_green;
   assign status_red_o            = st_ff.st_red;
   assign segment_o               = st_ff.seg;
   assign interlock_fault_o       = st_ff.fault;
   assign restart_lock_function_o = st_ff.lock_en;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_pair_equal: assert property (safety_output_a_o == safety_output_b_o)
      else $error("safety outputs differ");
   chk_lamp_inverse: assert property (reset_button_line_o == !safety_output_a_o)
      else $error("lamp not inverse of outputs");
   chk_red_locked: assert property (red_lamp_o != safety_output_a_o)
      else $error("red lamp wrong");
   chk_yellow_ready: assert property (yellow_lamp_o |-> !safety_output_a_o && restart_lock_function_o)
      else $error("yellow lamp while not ready");
   chk_trip_lock: assert property (safety_output_a_o && (!field_clear_i || power_fail_i)
                                   |=> !safety_output_a_o)
      else $error("outputs stay on after trip");
   chk_unlock_clear: assert property ($rose(safety_output_a_o) |-> $past(field_clear_i)
                                      && !$past(power_fail_i))
      else $error("unlock without clear field");
   chk_long_discard: assert property (st_ff.state == RIC_LOCKED && st_ff.lock_en && fall_w
                                      && st_ff.hold >= MAX_HOLD_CYC |=> !safety_output_a_o)
      else $error("long press unlocked");
   chk_short_fault: assert property (st_ff.state != RIC_FAULT && btn_w && st_ff.hold == SHORT_CYC - 32'h1
                                     |=> interlock_fault_o ##1 interlock_fault_o && !safety_output_a_o)
      else $error("stuck line not faulted");
   chk_green_steady: assert property (safety_output_a_o && !$past(marginal_align_i) |-> status_green_o)
      else $error("green not lit while on");
   chk_beam_lost: assert property (!$past(field_clear_i) |-> status_red_o && !status_green_o)
      else $error("lost beam not red");
   chk_seg_idle: assert property (!$past(align_display_en_i) |-> segment_o == `RIC_SEG_NONE)
      else $error("segments lit without alignment");

   cov_unlock: cover property (st_ff.lock_en && fall_w ##1 $rose(safety_output_a_o));
   cov_trip: cover property (safety_output_a_o ##1 !safety_output_a_o);
   cov_fault: cover property ($rose(interlock_fault_o));
   cov_auto_on: cover property (!st_ff.lock_en && $rose(safety_output_a_o));

endmodule // ric_top
`default_nettype wire

// ### hdl/ric_map.svh
`ifndef RIC_MAP_SVH
`define RIC_MAP_SVH

// ************************************************************
// clock and timing figures
// ************************************************************
`define RIC_CLK_KHZ      125000
`define RIC_MIN_HOLD_MS  150
`define RIC_MAX_HOLD_MS  4000
`define RIC_SHORT_MS     30000
`define RIC_FLASH_MS     500

// ************************************************************
// shared line time multiplex and debounce
// ************************************************************
`define RIC_MUX_RELEASE  8'hf0
`define RIC_MUX_SAMPLE   8'hff
`define RIC_DB_SAMPLES   4

// ************************************************************
// display patterns
// ************************************************************
`define RIC_SEG_ALL      7'h7f
`define RIC_SEG_NONE     7'h00

`endif

// ### hdl/ric_pkg.sv
package ric_pkg;

   // ************************************************************
   // interlock states
   // ************************************************************
   typedef enum logic [1:0] {
      RIC_LOCKED = 2'b00,
      RIC_ON     = 2'b01,
      RIC_FAULT  = 2'b10
   } ric_state_t;

   // debounce state
   typedef struct packed {
      logic       sync1;
      logic       sync2;
      logic [1:0] agree;
      logic       level;
   } ric_db_t;

   // interlock controller state, outputs included
   typedef struct packed {
      ric_state_t  state;
      logic        sel_sync1;
      logic        sel_sync2;
      logic        lock_en;
      logic        btn_prev;
      logic        armed;
      logic        req_ok;
      logic [31:0] hold;
      logic [7:0]  mux;
      logic [31:0] flash_cnt;
      logic        flash;
      logic        out_a;
      logic        out_b;
      logic        line;
      logic        line_oe;
      logic        red;
      logic        yellow;
      logic        st_green;
      logic        st_red;
      logic [6:0]  seg;
      logic        fault;
   } ric_st_t;

endpackage

// ### hdl/ric_debounce.sv
`timescale 1ns/1ns
`default_nettype none
`include "ric_map.svh"

module ric_debounce
   import ric_pkg::*;
#(
   parameter int DB_SAMPLES = `RIC_DB_SAMPLES
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic pin_i,      // raw shared line level
   input  wire logic sample_i,   // line is undriven, take a sample
   output logic      level_o     // debounced button level
);

   ric_db_t st_ff;   // registered state
   ric_db_t nxt_st;  // next state

   // ************************************************************
   // two-flop synchroniser, then a run of agreeing samples
   // ************************************************************
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.sync1 = pin_i;
      nxt_st.sync2 = st_ff.sync1;
      if (sample_i) begin
         // contact bounce restarts the run, so short spikes never flip the level
         if (st_ff.sync2 != st_ff.level) begin
            if (st_ff.agree == 2'(DB_SAMPLES - 1)) begin
               nxt_st.level = st_ff.sync2;
               nxt_st.agree = 2'h0;
            end else begin
               nxt_st.agree = st_ff.agree + 2'h1;
            end
         end else begin
            nxt_st.agree = 2'h0;
         end
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_o = st_ff.level;

endmodule // ric_debounce
`default_nettype wire

// ### testbench/ric_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// reset pushbutton with lamp, select wiring
// ************************************************************
module ric_partner (
   input  wire logic press_i,   // operator holds the button
   input  wire logic bridge_i,  // select bridged to the shared line
   input  wire logic lamp_i,    // lamp drive level from the receiver
   input  wire logic lamp_oe_i, // receiver driving the line
   output logic      line_o,    // resolved shared line level
   output logic      select_o   // select pin level
);
   // button closes to supply; lamp raises the line only while driven
   assign line_o   = press_i | (lamp_oe_i & lamp_i);
   // tied high keeps the lock on, bridged follows the line
   assign select_o = bridge_i ? line_o : 1'b1;
endmodule // ric_partner
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ric_pkg::*;
   // ************************************************************
   // stimulus and observation
   // ************************************************************
   logic        clk_i = 1'b0, rst_b_i = 1'b0, press = 1'b0, bridge = 1'b0, seen_clr = 1'b0;
   logic        field = 1'b0, marg = 1'b0, pfail = 1'b0, align = 1'b0;
   logic        line, sel, out_a, out_b, lamp, lamp_oe, red, yel, grn, sred, fault, lockf;
   logic [6:0]  seg;
   logic [2:0]  seen = 3'h0;  // all-on segments, all-off segments, green toggled
   logic        grn_q = 1'b0;
   logic [11:0] obs;
   typedef struct packed {logic [11:0] val; logic [11:0] mask;} ric_note_t;
   ric_note_t   q[$];         // expected observations, oldest first
   ric_note_t   n;
   int          miscompares = 0, checks_done = 0;
   logic [7:0]  lfsr = 8'h3b;

   always #4 clk_i = ~clk_i;

   ric_top #(.MIN_HOLD_CYC(32'h7d0), .MAX_HOLD_CYC(32'h1770), .SHORT_CYC(32'h4e20),
             .FLASH_CYC(32'h10)) i_dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .reset_button_line_i(line), .interlock_select_input_i(sel),
      .field_clear_i(field), .marginal_align_i(marg), .power_fail_i(pfail), .align_display_en_i(align),
      .safety_output_a_o(out_a), .safety_output_b_o(out_b), .reset_button_line_o(lamp),
      .reset_button_line_oe_o(lamp_oe), .red_lamp_o(red), .yellow_lamp_o(yel), .status_green_o(grn),
      .status_red_o(sred), .segment_o(seg), .interlock_fault_o(fault), .restart_lock_function_o(lockf));

   ric_partner i_btn (.press_i(press), .bridge_i(bridge), .lamp_i(lamp), .lamp_oe_i(lamp_oe),
                      .line_o(line), .select_o(sel));

   assign obs = {seen, grn, sred, fault, red, yel, out_a, out_b, lamp, lockf};

   // flashing is judged from what was seen over a window, not one sample
   always @(posedge clk_i) begin
      grn_q <= grn;
      if (seen_clr) seen <= 3'h0;
      else seen <= seen | {seg == 7'h7f, seg == 7'h00, grn != grn_q};
   end

   // ************************************************************
   // monitor: oldest note against the settled outputs
   // ************************************************************
   always @(negedge clk_i) begin
      if (out_a !== out_b) begin
         miscompares++;
         $display("ERROR output_pair expected %b seen %b", out_a, out_b);
      end
      // the lamp must never hold the line while the outputs are on
      if (lamp_oe !== 1'b0 && out_a === 1'b1) begin
         miscompares++;
         $display("ERROR lamp_drive expected 0 seen %b", lamp_oe);
      end
      if (q.size() > 0) begin
         n = q.pop_front();
         checks_done++;
         if ((obs & n.mask) !== n.val) begin
            miscompares++;
            $display("ERROR status expected %h seen %h", n.val, obs & n.mask);
         end
      end
   end

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask

   // note an expectation; the monitor takes it at the next falling edge
   task automatic note(input logic [11:0] v, input logic [11:0] m);
      q.push_back('{v, m});
      cyc(2);
   endtask

   // press for k cycles, then allow the release to pass the debounce
   task automatic push_btn(input int k);
      press <= 1'b1;
      cyc(k);
      press <= 1'b0;
      cyc(1400);
   endtask

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // watchdog sized well past the expected run of about 60000 cycles
   initial begin
      cyc(90000);
      miscompares++;
      $display("ERROR watchdog expected finish seen hang");
      end_sim();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      cyc(2);
      rst_b_i <= 1'b1;
      field   <= 1'b1;
      cyc(1400);
      note(12'h0b3, 12'h1ff);
      push_btn(1000);
      note(12'h0b3, 12'h1ff);
      $display("test short press done");
      push_btn(4000);
      note(12'h10d, 12'h1ff);
      seen_clr <= 1'b1;
      align    <= 1'b1;
      marg     <= 1'b1;
      cyc(1);
      seen_clr <= 1'b0;
      cyc(64);
      note(12'he00, 12'he00);
      align <= 1'b0;
      marg  <= 1'b0;
      field <= 1'b0;
      cyc(2);
      note(12'h0a3, 12'h1ff);
      field <= 1'b1;
      $display("test unlock and trip done");
      for (int i = 0; i < 3; i++) begin
         lfsr = lfsr_next(lfsr);
         push_btn(2400 + 8 * int'(lfsr));
         note(12'h10d, 12'h1ff);
         if (i % 2) pfail <= 1'b1;
         else field <= 1'b0;
         cyc(2);
         note(12'h0a3, 12'h1ef);
         pfail <= 1'b0;
         field <= 1'b1;
      end
      $display("test random holds done");
      push_btn(8000);
      note(12'h0b3, 12'h1ff);
      push_btn(25000);
      note(12'h0e3, 12'h1ef);
      $display("test long holds done");
      rst_b_i <= 1'b0;
      bridge  <= 1'b1;
      cyc(2);
      rst_b_i <= 1'b1;
      cyc(1400);
      note(12'h10c, 12'h1ff);
      field <= 1'b0;
      cyc(2);
      note(12'h0a2, 12'h1ff);
      field <= 1'b1;
      cyc(4);
      note(12'h10c, 12'h1ff);
      $display("test lock off done");
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
